//--- io_port_consts.svh
// register offsets, field positions and reset values of the port block
// assumes an 8-bit apb byte address and 32-bit apb data
//
// What this block does
// - second output port ORs data with pattern bits
// - first port ORs data, pattern, monitors, capstan
// - pattern ports float until first data write
// - ports c, i, j set direction per nibble
// - port d low bits per-bit, upper nibble shared
// - port e: two inputs, six outputs
// - three external irqs trigger on falling edges
// - nmi pin triggers on falling edge
// - port f upper nibble releases standby
// - port k direction set per bit
// - pwm4 and switching pins high at reset
// - reset pin driven low during power-on
// - playback pin pulled up in standby option
`ifndef IO_PORT_CONSTS_SVH
`define IO_PORT_CONSTS_SVH

`define OFS_PA_DAT   8'h00
`define OFS_PB_DAT   8'h04
`define OFS_PC_DAT   8'h08
`define OFS_PC_DIR   8'h0c
`define OFS_PD_DAT   8'h10
`define OFS_PD_DIR   8'h14
`define OFS_PE_DAT   8'h18
`define OFS_PF_DAT   8'h1c
`define OFS_PG_DAT   8'h20
`define OFS_PH_DAT   8'h24
`define OFS_PI_DAT   8'h28
`define OFS_PI_DIR   8'h2c
`define OFS_PJ_DAT   8'h30
`define OFS_PJ_DIR   8'h34
`define OFS_PK_DAT   8'h38
`define OFS_PK_DIR   8'h3c
`define OFS_IRQ_STAT 8'h40
`define OFS_IRQ_MASK 8'h44
`define OFS_CTRL     8'h48

`define IRQ_EXT_A    0
`define IRQ_EXT_B    1
`define IRQ_EXT_C    2
`define IRQ_NMI      3
`define IRQ_WAKE     4
`define IRQ_MASKABLE 5'h17
`define CTRL_STANDBY 0

`define PE_DAT_RST   6'h30
`define PH_DAT_RST   4'hf
`define DIR_RST      8'h00

`endif

//--- io_port_pkg.sv
// types shared by the port block
// assumes nothing beyond the compile order
`default_nettype none
package io_port_pkg;
  typedef logic [7:0] port_byte_t;
  typedef enum logic [1:0] {
    PWR_RUN     = 2'b01,
    PWR_STANDBY = 2'b10
  } power_state_t;
endpackage
`default_nettype wire

//--- port_ctl_if.sv
// carrier between the register file and one bidirectional port
// assumes write strobes are single-cycle pulses
`default_nettype none
interface port_ctl_if;
  import io_port_pkg::*;
  logic       wr_dat;
  logic       wr_dir;
  port_byte_t wdata;
  port_byte_t rdata;
  port_byte_t pin_in;
  port_byte_t pin_out;
  port_byte_t pin_oe_n;
  modport regs (output wr_dat, wr_dir, wdata, pin_in,
                input rdata, pin_out, pin_oe_n);
  modport port (input wr_dat, wr_dir, wdata, pin_in,
                output rdata, pin_out, pin_oe_n);
endinterface
`default_nettype wire

//--- falling_edge_irq.sv
// one-cycle pulse on a falling edge of a synchronous input
// assumes the input is already synchronous to clock_i
`default_nettype none
module falling_edge_irq
  import io_port_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic level_i,
  output logic      fall_o
);
  logic last;
  logic next_last;

  always_comb
  begin
    next_last = level_i;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      last <= 1'b1;
    else
      last <= next_last;
  end

  assign fall_o = last & ~level_i;

  chk_fall_only_edge: assert property (@(posedge clock_i) disable iff (!rst_n_i) fall_o |-> $past(level_i) && !level_i) else $error("pulse without a falling edge");
endmodule // falling_edge_irq
`default_nettype wire

//--- bidir_port.sv
// one 8-bit bidirectional port: data latch, direction, read path
// direction granularity per half chosen by parameters
`include "io_port_consts.svh"
`default_nettype none
module bidir_port
  import io_port_pkg::*;
#(
  parameter bit LOW_PER_BIT = 1'b0,
  parameter bit UP_PER_BIT  = 1'b0
)(
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  port_ctl_if.port  ctl
);
  port_byte_t dat;
  port_byte_t dir;
  port_byte_t next_dat;
  port_byte_t next_dir;
  port_byte_t out_en;

  always_comb
  begin
    next_dat = ctl.wr_dat ? ctl.wdata : dat;
    next_dir = ctl.wr_dir ? ctl.wdata : dir;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      dat <= 8'h00;
      dir <= `DIR_RST;
    end
    else
    begin
      dat <= next_dat;
      dir <= next_dir;
    end
  end

  // per-bit or whole-nibble direction
  always_comb
  begin
    out_en[3:0] = LOW_PER_BIT ? dir[3:0] : {4{dir[0]}};
    out_en[7:4] = UP_PER_BIT ? dir[7:4] : {4{dir[4]}};
  end

  assign ctl.pin_out  = dat;
  assign ctl.pin_oe_n = ~out_en;
  assign ctl.rdata    = (ctl.pin_in & ~out_en) | (dat & out_en);

  chk_dir_reset_in: assert property (@(posedge clock_i) $rose(rst_n_i) |-> ctl.pin_oe_n == 8'hff) else $error("port bit not input after reset");
endmodule // bidir_port
`default_nettype wire

//--- io_port_top.sv
// pin-level port logic with apb register access
// assumes all pins are synchronous to clock_i; reset is synchronous
`include "io_port_consts.svh"
`default_nettype none
module io_port_top
  import io_port_pkg::*;
#(
  parameter bit POR_OPTION     = 1'b1,
  parameter bit BUF_AMP_OPTION = 1'b1
)(
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic [10:0] pattern_gen_out_i,
  input  wire logic        capstan_ctrl_out_i,
  input  wire logic        track_monitor_1_i,
  input  wire logic        track_monitor_2_i,
  input  wire logic        track_monitor_3_i,
  input  wire logic        track_monitor_a_i,
  output logic [7:0]       porta_o,
  output logic [7:0]       porta_oe_n_o,
  output logic [7:0]       portb_o,
  output logic [7:0]       portb_oe_n_o,
  input  wire logic [7:0]  portc_i,
  output logic [7:0]       portc_o,
  output logic [7:0]       portc_oe_n_o,
  input  wire logic [7:0]  portd_i,
  output logic [7:0]       portd_o,
  output logic [7:0]       portd_oe_n_o,
  input  wire logic [1:0]  porte_i,
  input  wire logic [4:0]  pwm_i,
  input  wire logic        switching_pulse_out_i,
  output logic [7:2]       porte_o,
  output logic [7:2]       porte_oe_n_o,
  input  wire logic [7:0]  portf_i,
  input  wire logic [7:0]  portg_i,
  input  wire logic [3:0]  porth_i,
  output logic [3:0]       porth_od_o,
  output logic [3:0]       porth_od_oe_n_o,
  input  wire logic [7:0]  porti_i,
  output logic [7:0]       porti_o,
  output logic [7:0]       porti_oe_n_o,
  input  wire logic [7:0]  portj_i,
  output logic [7:0]       portj_o,
  output logic [7:0]       portj_oe_n_o,
  input  wire logic [3:0]  portk_i,
  output logic [3:0]       portk_o,
  output logic [3:0]       portk_oe_n_o,
  input  wire logic        nmi_n_i,
  input  wire logic        por_active_i,
  output logic             rst_pin_o,
  output logic             rst_pin_oe_n_o,
  output logic             playback_data_pullup_o,
  output logic             standby_o,
  output logic             irq_o,
  output logic             nmi_o
);
  port_ctl_if c_if ();
  port_ctl_if d_if ();
  port_ctl_if i_if ();
  port_ctl_if j_if ();
  port_ctl_if k_if ();

  port_byte_t   pa_dat;
  port_byte_t   pb_dat;
  logic [7:2]   pe_dat;
  logic [3:0]   ph_dat;
  logic         pa_live;
  logic         pb_live;
  logic         pe_live;
  logic [4:0]   irq_stat;
  logic [4:0]   irq_mask;
  power_state_t pwr;
  port_byte_t   pa_pin;
  port_byte_t   pb_pin;
  logic [7:2]   pe_pin;
  logic [31:0]  rdata;
  logic         rd_err;

  port_byte_t   next_pa_dat;
  port_byte_t   next_pb_dat;
  logic [7:2]   next_pe_dat;
  logic [3:0]   next_ph_dat;
  logic         next_pa_live;
  logic         next_pb_live;
  logic         next_pe_live;
  logic [4:0]   next_irq_stat;
  logic [4:0]   next_irq_mask;
  power_state_t next_pwr;
  port_byte_t   next_pa_pin;
  port_byte_t   next_pb_pin;
  logic [7:2]   next_pe_pin;
  logic [31:0]  next_rdata;
  logic         next_rd_err;

  logic         setup;
  logic         wr;
  logic [4:0]   events;
  logic [3:0]   wake_fall;
  logic         fall_a;
  logic         fall_b;
  logic         fall_c;
  logic         fall_nmi;
  logic [4:0]   stat_clr;
  port_byte_t   wb;

  assign setup = psel_i & ~penable_i;
  assign wr    = psel_i & penable_i & pwrite_i;
  assign wb    = pwdata_i[7:0];

  // bidirectional ports
  assign c_if.wr_dat = wr && paddr_i == `OFS_PC_DAT;
  assign c_if.wr_dir = wr && paddr_i == `OFS_PC_DIR;
  assign d_if.wr_dat = wr && paddr_i == `OFS_PD_DAT;
  assign d_if.wr_dir = wr && paddr_i == `OFS_PD_DIR;
  assign i_if.wr_dat = wr && paddr_i == `OFS_PI_DAT;
  assign i_if.wr_dir = wr && paddr_i == `OFS_PI_DIR;
  assign j_if.wr_dat = wr && paddr_i == `OFS_PJ_DAT;
  assign j_if.wr_dir = wr && paddr_i == `OFS_PJ_DIR;
  assign k_if.wr_dat = wr && paddr_i == `OFS_PK_DAT;
  assign k_if.wr_dir = wr && paddr_i == `OFS_PK_DIR;
  assign c_if.wdata  = wb;
  assign d_if.wdata  = wb;
  assign i_if.wdata  = wb;
  assign j_if.wdata  = wb;
  assign k_if.wdata  = {4'h0, wb[3:0]};
  assign c_if.pin_in = portc_i;
  assign d_if.pin_in = portd_i;
  assign i_if.pin_in = porti_i;
  assign j_if.pin_in = portj_i;
  assign k_if.pin_in = {4'h0, portk_i};

  bidir_port #(.LOW_PER_BIT(1'b0), .UP_PER_BIT(1'b0)) u_pc
    (.clock_i(clock_i), .rst_n_i(rst_n_i), .ctl(c_if.port));
  bidir_port #(.LOW_PER_BIT(1'b1), .UP_PER_BIT(1'b0)) u_pd
    (.clock_i(clock_i), .rst_n_i(rst_n_i), .ctl(d_if.port));
  bidir_port #(.LOW_PER_BIT(1'b0), .UP_PER_BIT(1'b0)) u_pi
    (.clock_i(clock_i), .rst_n_i(rst_n_i), .ctl(i_if.port));
  bidir_port #(.LOW_PER_BIT(1'b0), .UP_PER_BIT(1'b0)) u_pj
    (.clock_i(clock_i), .rst_n_i(rst_n_i), .ctl(j_if.port));
  bidir_port #(.LOW_PER_BIT(1'b1), .UP_PER_BIT(1'b1)) u_pk
    (.clock_i(clock_i), .rst_n_i(rst_n_i), .ctl(k_if.port));

  assign portc_o      = c_if.pin_out;
  assign portc_oe_n_o = c_if.pin_oe_n;
  assign portd_o      = d_if.pin_out;
  assign portd_oe_n_o = d_if.pin_oe_n;
  assign porti_o      = i_if.pin_out;
  assign porti_oe_n_o = i_if.pin_oe_n;
  assign portj_o      = j_if.pin_out;
  assign portj_oe_n_o = j_if.pin_oe_n;
  assign portk_o      = k_if.pin_out[3:0];
  assign portk_oe_n_o = k_if.pin_oe_n[3:0];

  // interrupt edges
  falling_edge_irq u_fa (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .level_i(porte_i[0]), .fall_o(fall_a));
  falling_edge_irq u_fb (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .level_i(porth_i[3]), .fall_o(fall_b));
  falling_edge_irq u_fc (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .level_i(porte_i[1]), .fall_o(fall_c));
  falling_edge_irq u_fn (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .level_i(nmi_n_i), .fall_o(fall_nmi));

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_wake
      falling_edge_irq u_fw (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .level_i(portf_i[g+4]), .fall_o(wake_fall[g]));
    end
  endgenerate

  always_comb
  begin
    events = 5'h00;
    events[`IRQ_EXT_A] = fall_a;
    events[`IRQ_EXT_B] = fall_b;
    events[`IRQ_EXT_C] = fall_c;
    events[`IRQ_NMI]   = fall_nmi;
    events[`IRQ_WAKE]  = (pwr == PWR_STANDBY) && (|wake_fall);
    stat_clr = (wr && paddr_i == `OFS_IRQ_STAT) ? pwdata_i[4:0] : 5'h00;
  end

  // registers, pins and power state
  always_comb
  begin
    next_pa_dat   = pa_dat;
    next_pb_dat   = pb_dat;
    next_pe_dat   = pe_dat;
    next_ph_dat   = ph_dat;
    next_pa_live  = pa_live;
    next_pb_live  = pb_live;
    next_pe_live  = pe_live;
    next_irq_mask = irq_mask;
    next_pwr      = pwr;
    if (wr)
    begin
      if (paddr_i == `OFS_PA_DAT)
      begin
        next_pa_dat  = wb;
        next_pa_live = 1'b1;
      end
      else if (paddr_i == `OFS_PB_DAT)
      begin
        next_pb_dat  = wb;
        next_pb_live = 1'b1;
      end
      else if (paddr_i == `OFS_PE_DAT)
      begin
        next_pe_dat  = wb[7:2];
        next_pe_live = 1'b1;
      end
      else if (paddr_i == `OFS_PH_DAT)
        next_ph_dat = wb[7:4];
      else if (paddr_i == `OFS_IRQ_MASK)
        next_irq_mask = pwdata_i[4:0];
    end
    // set wins over a simultaneous clear
    next_irq_stat = (irq_stat & ~stat_clr) | events;
    case (pwr)
      PWR_RUN:
        if (wr && paddr_i == `OFS_CTRL && pwdata_i[`CTRL_STANDBY])
          next_pwr = PWR_STANDBY;
      PWR_STANDBY:
        if (|wake_fall)
          next_pwr = PWR_RUN;
      default:
        next_pwr = PWR_RUN;
    endcase
    next_pb_pin = pb_dat | pattern_gen_out_i[7:0];
    next_pa_pin = pa_dat | {track_monitor_2_i, track_monitor_a_i,
                            track_monitor_3_i, track_monitor_1_i,
                            capstan_ctrl_out_i,
                            pattern_gen_out_i[10:8]};
    next_pe_pin = pe_dat | {switching_pulse_out_i, pwm_i};
  end

  // read path, sampled in the setup cycle
  always_comb
  begin
    next_rdata  = 32'h0;
    next_rd_err = 1'b0;
    if (paddr_i == `OFS_PA_DAT)
      next_rdata[7:0] = pa_dat;
    else if (paddr_i == `OFS_PB_DAT)
      next_rdata[7:0] = pb_dat;
    else if (paddr_i == `OFS_PC_DAT || paddr_i == `OFS_PC_DIR)
      next_rdata[7:0] = c_if.rdata;
    else if (paddr_i == `OFS_PD_DAT || paddr_i == `OFS_PD_DIR)
      next_rdata[7:0] = d_if.rdata;
    else if (paddr_i == `OFS_PE_DAT)
      next_rdata[7:0] = {pe_dat, porte_i};
    else if (paddr_i == `OFS_PF_DAT)
      next_rdata[7:0] = portf_i;
    else if (paddr_i == `OFS_PG_DAT)
      next_rdata[7:0] = portg_i;
    else if (paddr_i == `OFS_PH_DAT)
      next_rdata[7:0] = {ph_dat, porth_i};
    else if (paddr_i == `OFS_PI_DAT || paddr_i == `OFS_PI_DIR)
      next_rdata[7:0] = i_if.rdata;
    else if (paddr_i == `OFS_PJ_DAT || paddr_i == `OFS_PJ_DIR)
      next_rdata[7:0] = j_if.rdata;
    else if (paddr_i == `OFS_PK_DAT || paddr_i == `OFS_PK_DIR)
      next_rdata[7:0] = k_if.rdata;
    else if (paddr_i == `OFS_IRQ_STAT)
      next_rdata[4:0] = irq_stat;
    else if (paddr_i == `OFS_IRQ_MASK)
      next_rdata[4:0] = irq_mask;
    else if (paddr_i == `OFS_CTRL)
      next_rdata[`CTRL_STANDBY] = (pwr == PWR_STANDBY);
    else
      next_rd_err = 1'b1;
    if (!setup)
    begin
      next_rdata  = rdata;
      next_rd_err = rd_err;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      pa_dat   <= 8'h00;
      pb_dat   <= 8'h00;
      pe_dat   <= `PE_DAT_RST;
      ph_dat   <= `PH_DAT_RST;
      pa_live  <= 1'b0;
      pb_live  <= 1'b0;
      pe_live  <= 1'b0;
      irq_stat <= 5'h00;
      irq_mask <= 5'h00;
      pwr      <= PWR_RUN;
      pa_pin   <= 8'h00;
      pb_pin   <= 8'h00;
      pe_pin   <= `PE_DAT_RST;
      rdata    <= 32'h0;
      rd_err   <= 1'b0;
    end
    else
    begin
      pa_dat   <= next_pa_dat;
      pb_dat   <= next_pb_dat;
      pe_dat   <= next_pe_dat;
      ph_dat   <= next_ph_dat;
      pa_live  <= next_pa_live;
      pb_live  <= next_pb_live;
      pe_live  <= next_pe_live;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      pwr      <= next_pwr;
      pa_pin   <= next_pa_pin;
      pb_pin   <= next_pb_pin;
      pe_pin   <= next_pe_pin;
      rdata    <= next_rdata;
      rd_err   <= next_rd_err;
    end
  end

  assign porta_o      = pa_pin;
  assign porta_oe_n_o = {8{~pa_live}};
  assign portb_o      = pb_pin;
  assign portb_oe_n_o = {8{~pb_live}};
  assign porte_o      = pe_pin;
  // pwm4 and switching pins always driven, pwm0-3 after first write
  assign porte_oe_n_o = {2'b00, {4{~pe_live}}};
  // open drain: pull low where the latch holds zero
  assign porth_od_o      = 4'h0;
  assign porth_od_oe_n_o = ph_dat;
  assign rst_pin_o      = 1'b0;
  assign rst_pin_oe_n_o = ~(POR_OPTION & por_active_i);
  assign playback_data_pullup_o =
    BUF_AMP_OPTION & (pwr == PWR_STANDBY);
  assign standby_o = (pwr == PWR_STANDBY);
  assign irq_o     = |(irq_stat & irq_mask & `IRQ_MASKABLE);
  assign nmi_o     = irq_stat[`IRQ_NMI];
  assign prdata_o  = rdata;
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & rd_err;

  chk_pb_or_gate: assert property (@(posedge clock_i) disable iff (!rst_n_i) rst_n_i |=> portb_o == ($past(pb_dat) | $past(pattern_gen_out_i[7:0]))) else $error("port b not data or pattern");
  chk_pa_capstan: assert property (@(posedge clock_i) disable iff (!rst_n_i) rst_n_i && capstan_ctrl_out_i |=> porta_o[3]) else $error("capstan bit not on port a");
  chk_pa_hiz_reset: assert property (@(posedge clock_i) disable iff (!rst_n_i) !pa_live && !(wr && paddr_i == `OFS_PA_DAT) |=> porta_oe_n_o == 8'hff) else $error("port a driven before write");
  chk_pb_live_write: assert property (@(posedge clock_i) disable iff (!rst_n_i) wr && paddr_i == `OFS_PB_DAT |=> portb_oe_n_o == 8'h00 ##1 portb_oe_n_o == 8'h00) else $error("port b not enabled by write");
  chk_irq_ext_edge: assert property (@(posedge clock_i) disable iff (!rst_n_i) $fell(porte_i[0]) |=> irq_stat[`IRQ_EXT_A]) else $error("falling edge lost");
  chk_nmi_unmasked: assert property (@(posedge clock_i) disable iff (!rst_n_i) $fell(nmi_n_i) |=> nmi_o) else $error("nmi not raised");
  chk_wake_release: assert property (@(posedge clock_i) disable iff (!rst_n_i) standby_o && (|wake_fall) |=> !standby_o && irq_stat[`IRQ_WAKE]) else $error("standby not released");
  chk_swp_high_rst: assert property (@(posedge clock_i) $rose(rst_n_i) |-> porte_o[7:6] == 2'b11 && porte_oe_n_o[7:6] == 2'b00 && porte_oe_n_o[5:2] == 4'hf) else $error("port e reset pins wrong");
  chk_rst_pin_drive: assert property (@(posedge clock_i) rst_pin_oe_n_o == !(POR_OPTION && por_active_i) && !rst_pin_o) else $error("reset pin drive wrong");
  chk_pullup_standby: assert property (@(posedge clock_i) disable iff (!rst_n_i) playback_data_pullup_o |-> standby_o) else $error("pullup outside standby");
endmodule // io_port_top
`default_nettype wire

//--- board_pins.sv
// board-side model of one group of bidirectional pins
// assumes oe_n low means the device drives the pin
`default_nettype none
module board_pins #(
  parameter int W = 8
)(
  input  wire logic [W-1:0] drv_i,
  input  wire logic [W-1:0] oe_n_i,
  input  wire logic [W-1:0] ext_i,
  output logic [W-1:0]      pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // board drives only the bits the device releases
  always_comb
  begin
    for (int b = 0; b < W; b++)
      pin_o[b] = oe_n_i[b] ? ext_i[b] : drv_i[b];
  end
endmodule // board_pins
`default_nettype wire

//--- testbench.sv
// self-checking bench for the port block over apb
// assumes zero or more wait states and a board model on bidir pins
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o;
  logic        pslverr_o, capstan_ctrl_out_i, switching_pulse_out_i;
  logic        track_monitor_1_i, track_monitor_2_i, track_monitor_3_i;
  logic        track_monitor_a_i, nmi_n_i, por_active_i, rst_pin_o;
  logic        rst_pin_oe_n_o, playback_data_pullup_o, standby_o, irq_o;
  logic        nmi_o, slverr;
  logic [7:0]  paddr_i, porta_o, porta_oe_n_o, portb_o, portb_oe_n_o;
  logic [7:0]  portc_i, portc_o, portc_oe_n_o, portd_i, portd_o;
  logic [7:0]  portd_oe_n_o, porti_i, porti_o, porti_oe_n_o, portj_i;
  logic [7:0]  portj_o, portj_oe_n_o, portf_i, portg_i, ext;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [10:0] pattern_gen_out_i;
  logic [4:0]  pwm_i;
  logic [1:0]  porte_i;
  logic [7:2]  porte_o, porte_oe_n_o;
  logic [3:0]  porth_i, porth_od_o, porth_od_oe_n_o, portk_i, portk_o;
  logic [3:0]  portk_oe_n_o;
  int          n_errors, comparisons;

  io_port_top io_port_top_i (.clock_i, .rst_n_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .pattern_gen_out_i, .capstan_ctrl_out_i, .track_monitor_1_i,
    .track_monitor_2_i, .track_monitor_3_i, .track_monitor_a_i, .porta_o,
    .porta_oe_n_o, .portb_o, .portb_oe_n_o, .portc_i, .portc_o,
    .portc_oe_n_o, .portd_i, .portd_o, .portd_oe_n_o, .porte_i, .pwm_i,
    .switching_pulse_out_i, .porte_o, .porte_oe_n_o, .portf_i, .portg_i,
    .porth_i, .porth_od_o, .porth_od_oe_n_o, .porti_i, .porti_o,
    .porti_oe_n_o, .portj_i, .portj_o, .portj_oe_n_o, .portk_i, .portk_o,
    .portk_oe_n_o, .nmi_n_i, .por_active_i, .rst_pin_o, .rst_pin_oe_n_o,
    .playback_data_pullup_o, .standby_o, .irq_o, .nmi_o);
  board_pins #(8) bc (.drv_i(portc_o), .oe_n_i(portc_oe_n_o), .ext_i(ext),
    .pin_o(portc_i));
  board_pins #(8) bd (.drv_i(portd_o), .oe_n_i(portd_oe_n_o), .ext_i(ext),
    .pin_o(portd_i));
  board_pins #(8) bi (.drv_i(porti_o), .oe_n_i(porti_oe_n_o), .ext_i(ext),
    .pin_o(porti_i));
  board_pins #(8) bj (.drv_i(portj_o), .oe_n_i(portj_oe_n_o), .ext_i(ext),
    .pin_o(portj_i));
  board_pins #(4) bk (.drv_i(portk_o), .oe_n_i(portk_oe_n_o),
    .ext_i(ext[3:0]), .pin_o(portk_i));

  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  task summarize;
    if (n_errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task check_pin(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task check_reg(input logic [31:0] exp);
    comparisons++;
    if (rd !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, rd, exp);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    // hold the request until pready is sampled high
    do @(posedge clock_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    slverr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  initial
  begin
    repeat (5000) @(posedge clock_i);
    n_errors++;
    summarize();
  end

  initial
  begin
    {rst_n_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    pattern_gen_out_i = 11'h530;
    {capstan_ctrl_out_i, track_monitor_1_i, track_monitor_2_i} = 3'b101;
    {track_monitor_3_i, track_monitor_a_i} = 2'b01;
    {pwm_i, switching_pulse_out_i} = 6'b010100;
    {porte_i, porth_i, nmi_n_i, portf_i} = {2'h3, 4'hf, 1'b1, 8'hf0};
    {portg_i, por_active_i, ext} = {8'h00, 1'b0, 8'h3c};
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    tick(1);
    check_pin(porta_oe_n_o, 8'hff);
    check_pin(portb_oe_n_o, 8'hff);
    check_pin({portc_oe_n_o & portd_oe_n_o}, 8'hff);
    check_pin({porti_oe_n_o & portj_oe_n_o}, 8'hff);
    check_pin(8'(portk_oe_n_o), 8'h0f);
    check_pin(8'(porte_o), 8'h3a);
    check_pin(8'(porte_oe_n_o), 8'h0f);
    check_pin(8'(porth_od_oe_n_o), 8'h0f);
    check_pin(8'(porth_od_o), 8'h00);
    apb(1'b1, 8'h04, 32'h05);
    apb(1'b1, 8'h00, 32'h02);
    apb(1'b1, 8'h18, 32'h00);
    tick(2);
    check_pin(portb_o, 8'h35);
    check_pin(porta_o, 8'hcf);
    check_pin(porta_oe_n_o | portb_oe_n_o, 8'h00);
    check_pin(8'(porte_o), 8'h0a);
    check_pin(8'(porte_oe_n_o), 8'h00);
    apb(1'b0, 8'h18, 32'h00);
    check_reg(32'h03);
    apb(1'b1, 8'h08, 32'ha5);
    apb(1'b1, 8'h10, 32'ha5);
    apb(1'b1, 8'h28, 32'ha5);
    apb(1'b1, 8'h30, 32'ha5);
    apb(1'b1, 8'h38, 32'ha5);
    apb(1'b1, 8'h0c, 32'h01);
    apb(1'b1, 8'h2c, 32'h10);
    apb(1'b1, 8'h34, 32'h11);
    apb(1'b1, 8'h14, 32'h15);
    apb(1'b1, 8'h3c, 32'h09);
    apb(1'b1, 8'h24, 32'h50);
    tick(1);
    check_pin(portc_oe_n_o, 8'hf0);
    check_pin(porti_oe_n_o, 8'h0f);
    check_pin(portj_oe_n_o, 8'h00);
    check_pin(portd_oe_n_o, 8'h0a);
    check_pin(8'(portk_oe_n_o), 8'h06);
    check_pin(8'(porth_od_oe_n_o), 8'h05);
    apb(1'b0, 8'h08, 32'h0);
    check_reg(32'h35);
    apb(1'b0, 8'h28, 32'h0);
    check_reg(32'hac);
    apb(1'b0, 8'h30, 32'h0);
    check_reg(32'ha5);
    apb(1'b0, 8'h10, 32'h0);
    check_reg(32'had);
    apb(1'b0, 8'h38, 32'h0);
    check_reg(32'h05);
    apb(1'b0, 8'h24, 32'h0);
    check_reg(32'h5f);
    apb(1'b0, 8'hfc, 32'h0);
    check_reg(32'h0);
    check_pin(8'(slverr), 8'h01);
    apb(1'b1, 8'h44, 32'h07);
    porte_i[0] <= 1'b0;
    tick(3);
    check_pin(8'(irq_o), 8'h01);
    apb(1'b1, 8'h40, 32'h01);
    tick(3);
    check_pin(8'(irq_o), 8'h00);
    apb(1'b0, 8'h40, 32'h0);
    check_reg(32'h00);
    porth_i[3] <= 1'b0;
    tick(3);
    check_pin(8'(irq_o), 8'h01);
    apb(1'b1, 8'h44, 32'h00);
    porte_i[1] <= 1'b0;
    tick(3);
    check_pin(8'(irq_o), 8'h00);
    apb(1'b0, 8'h40, 32'h0);
    check_reg(32'h06);
    apb(1'b1, 8'h40, 32'h1f);
    nmi_n_i <= 1'b0;
    tick(3);
    check_pin(8'(nmi_o), 8'h01);
    apb(1'b1, 8'h48, 32'h01);
    tick(1);
    check_pin(8'({standby_o, playback_data_pullup_o}), 8'h03);
    @(posedge clock_i);
    portf_i[7] <= 1'b0;
    tick(3);
    check_pin(8'({standby_o, playback_data_pullup_o}), 8'h00);
    apb(1'b0, 8'h40, 32'h0);
    check_reg(32'h18);
    por_active_i <= 1'b1;
    tick(1);
    check_pin(8'({rst_pin_o, rst_pin_oe_n_o}), 8'h00);
    @(posedge clock_i);
    por_active_i <= 1'b0;
    tick(1);
    check_pin(8'(rst_pin_oe_n_o), 8'h01);
    summarize();
  end
endmodule // testbench
`default_nettype wire
